// >>> verilog/brs_slice.sv
// Registered rotator slice with three-state outputs and AXI4-Lite registers
//
// Notes on behaviour
// - Rotate eight bits left by zero to seven
// - Bits leaving top re-enter at bottom
// - Result registered on rising clock edge
// - Outputs three-stated when drive is disabled
// - Set loads all ones, overriding the rotate result
// - Thirteen inputs in, four registered bits out
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module brs_slice
	import brs_pkg::*;
#(
	parameter int OPERAND_W_P = OPERAND_W,
	parameter int AMOUNT_W_P  = AMOUNT_W,
	parameter int SLICE_W_P   = SLICE_W
) (
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// Data path inputs from the ALU
	input  wire logic [OPERAND_W_P-1:0] operand,
	input  wire logic [AMOUNT_W_P-1:0]  rotate_amount,
	input  wire logic                   set_n,
	input  wire logic                   drive_en_n,
	// Result pins towards the data bus
	output logic      [SLICE_W_P-1:0]   slice_result,
	output logic      [SLICE_W_P-1:0]   slice_result_oe_n,
	// AXI4-Lite write address
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [3:0]             s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	// AXI4-Lite write response
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic      [1:0]             s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [3:0]             s_axi_araddr,
	// AXI4-Lite read data
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic      [31:0]            s_axi_rdata,
	output logic      [1:0]             s_axi_rresp
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [SLICE_W_P-1:0]   rotated;
	logic [SLICE_W_P-1:0]   result_q,    result_d;
	logic                   drive_off_q, drive_off_d;
	logic                   soft_set_q,  soft_set_d;
	logic [OPERAND_W_P-1:0] op_seen_q,   op_seen_d;
	logic [AMOUNT_W_P-1:0]  amt_seen_q,  amt_seen_d;
	logic                   aw_full_q,   aw_full_d;
	logic [3:0]             aw_addr_q,   aw_addr_d;
	logic                   w_full_q,    w_full_d;
	logic [31:0]            w_data_q,    w_data_d;
	logic [3:0]             w_strb_q,    w_strb_d;
	logic                   bvalid_q,    bvalid_d;
	logic [1:0]             bresp_q,     bresp_d;
	logic                   rvalid_q,    rvalid_d;
	logic [31:0]            rdata_q,     rdata_d;
	logic [1:0]             rresp_q,     rresp_d;
	logic                   load_ones;
	logic                   drive_on;
	logic                   wr_fire;

	// ****************************************************************
	// Rotate network
	// ****************************************************************
	brs_rotator #(
		.OPERAND_W_P (OPERAND_W_P),
		.AMOUNT_W_P  (AMOUNT_W_P),
		.SLICE_W_P   (SLICE_W_P)
	) u_rot (
		.operand (operand),
		.amount  (rotate_amount),
		.rotated (rotated)
	);

	// ****************************************************************
	// Pipeline register and output drivers
	// ****************************************************************
	// Set from the pin or from software overrides the rotate result
	assign load_ones = !set_n || soft_set_q;
	// Either the pin or the control bit can take the drivers off the bus
	assign drive_on = !drive_en_n && !drive_off_q;

	// Next result, sampled regardless of the drivers
	always_comb begin
		result_d   = rotated;
		op_seen_d  = operand;
		amt_seen_d = rotate_amount;
		if (load_ones) begin
			result_d = '1;
		end
	end

	// Register the result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_q   <= RESULT_RST;
			op_seen_q  <= '0;
			amt_seen_q <= '0;
		end else begin
			result_q   <= result_d;
			op_seen_q  <= op_seen_d;
			amt_seen_q <= amt_seen_d;
		end
	end

	// Pins: data from the register, enable low while driving
	assign slice_result      = result_q;
	assign slice_result_oe_n = {SLICE_W_P{!drive_on}};

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready  = !w_full_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;

	// Capture address and data in either order, then answer
	always_comb begin
		aw_full_d   = aw_full_q;
		aw_addr_d   = aw_addr_q;
		w_full_d    = w_full_q;
		w_data_d    = w_data_q;
		w_strb_d    = w_strb_q;
		bvalid_d    = bvalid_q;
		bresp_d     = bresp_q;
		drive_off_d = drive_off_q;
		soft_set_d  = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			case (aw_addr_q)
				CTRL_OFS: begin
					bresp_d = RESP_OKAY;
					if (w_strb_q[0]) begin
						drive_off_d = w_data_q[CTRL_DRIVE_OFF_BIT];
						soft_set_d  = w_data_q[CTRL_SOFT_SET_BIT];
					end
				end
				STATUS_OFS, SAMPLE_OFS: begin
					bresp_d = RESP_SLVERR;
				end
				default: begin
					bresp_d = RESP_DECERR;
				end
			endcase
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// Register the write path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q   <= 1'b0;
			aw_addr_q   <= 4'h0;
			w_full_q    <= 1'b0;
			w_data_q    <= 32'h0;
			w_strb_q    <= 4'h0;
			bvalid_q    <= 1'b0;
			bresp_q     <= RESP_OKAY;
			drive_off_q <= CTRL_DRIVE_OFF_RST;
			soft_set_q  <= 1'b0;
		end else begin
			aw_full_q   <= aw_full_d;
			aw_addr_q   <= aw_addr_d;
			w_full_q    <= w_full_d;
			w_data_q    <= w_data_d;
			w_strb_q    <= w_strb_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			drive_off_q <= drive_off_d;
			soft_set_q  <= soft_set_d;
		end
	end

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// Decode the read as the address is taken; the answer appears one cycle later
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d  = 32'h0;
			rresp_d  = RESP_OKAY;
			case (s_axi_araddr)
				CTRL_OFS: begin
					rdata_d[CTRL_DRIVE_OFF_BIT] = drive_off_q;
				end
				STATUS_OFS: begin
					rdata_d[STATUS_RESULT_LSB +: SLICE_W_P] = result_q;
					rdata_d[STATUS_DRIVING_BIT]             = drive_on;
				end
				SAMPLE_OFS: begin
					rdata_d[SAMPLE_OPERAND_LSB +: OPERAND_W_P] = op_seen_q;
					rdata_d[SAMPLE_AMOUNT_LSB +: AMOUNT_W_P]   = amt_seen_q;
				end
				default: begin
					rresp_d = RESP_DECERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// Register the read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	// Reference rotation built independently of the selector network
	logic [2*OPERAND_W_P-1:0] ref_dbl;
	logic [OPERAND_W_P-1:0]   ref_rot;
	assign ref_dbl = {operand, operand} << rotate_amount;
	assign ref_rot = ref_dbl[2*OPERAND_W_P-1 -: OPERAND_W_P];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_rotate_value: assert property (
		!load_ones |=> slice_result == $past(ref_rot[SLICE_W_P-1:0]))
		else $error("rotated nibble wrong");

	chk_wrap_around: assert property (
		!load_ones && rotate_amount == 3'h3
		|=> slice_result[2:0] == $past(operand[7:5]))
		else $error("top bits did not wrap to bottom");

	chk_one_stage: assert property (
		!load_ones ##1 $stable(operand) && $stable(rotate_amount) && !load_ones
		|=> $stable(slice_result))
		else $error("result not a single pipeline stage");

	chk_hiz_drive: assert property (
		slice_result_oe_n == {SLICE_W_P{drive_en_n || drive_off_q}})
		else $error("output enable does not follow drive control");

	chk_set_ones: assert property (
		!set_n |=> slice_result == '1)
		else $error("set did not load all ones");

	chk_soft_set: assert property (
		wr_fire && aw_addr_q == CTRL_OFS && w_strb_q[0] && w_data_q[CTRL_SOFT_SET_BIT]
		|=> ##1 slice_result == '1)
		else $error("software set did not load all ones");

	chk_all_inputs: assert property (
		!load_ones && rotate_amount == 3'h4 |=> slice_result == $past(operand[7:4]))
		else $error("upper operand bits not reaching the slice");

	chk_hidden_update: assert property (
		slice_result_oe_n[0] && !load_ones
		|=> slice_result == $past(ref_rot[SLICE_W_P-1:0]))
		else $error("register stalled while outputs disabled");

	chk_bresp_hold: assert property (
		bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped early");

	chk_read_latency: assert property (
		s_axi_arvalid && s_axi_arready |=> rvalid_q)
		else $error("read answer not one cycle after address");

	cov_rotate_seven: cover property (!load_ones && rotate_amount == 3'h7 ##1 1'b1);
	cov_set_pin: cover property (!set_n ##1 set_n);
	cov_hidden: cover property (!drive_on ##1 drive_on);
	cov_write_ctrl: cover property (wr_fire && aw_addr_q == CTRL_OFS);

endmodule

// >>> verilog/brs_pkg.sv
// Constants shared by the rotator slice and its register interface
package brs_pkg;

	// ****************************************************************
	// Data path shape
	// ****************************************************************
	localparam int OPERAND_W     = 8;
	localparam int AMOUNT_W      = 3;
	localparam int SLICE_W       = 4;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] SAMPLE_OFS = 4'h8;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_DRIVE_OFF_BIT = 0;
	localparam int CTRL_SOFT_SET_BIT  = 1;
	localparam int STATUS_RESULT_LSB  = 0;
	localparam int STATUS_DRIVING_BIT = 4;
	localparam int SAMPLE_OPERAND_LSB = 0;
	localparam int SAMPLE_AMOUNT_LSB  = 8;

	// ****************************************************************
	// Reset values and responses
	// ****************************************************************
	localparam logic       CTRL_DRIVE_OFF_RST = 1'b0;
	localparam logic [3:0] RESULT_RST         = 4'h0;
	localparam logic [1:0] RESP_OKAY          = 2'h0;
	localparam logic [1:0] RESP_SLVERR        = 2'h2;
	localparam logic [1:0] RESP_DECERR        = 2'h3;

endpackage

// >>> verilog/brs_rotator.sv
// Combinational rotate network for one output nibble
`timescale 1ns/100ps

module brs_rotator
	import brs_pkg::*;
#(
	parameter int OPERAND_W_P = OPERAND_W,
	parameter int AMOUNT_W_P  = AMOUNT_W,
	parameter int SLICE_W_P   = SLICE_W
) (
	// Operand and rotate amount
	input  wire logic [OPERAND_W_P-1:0] operand,
	input  wire logic [AMOUNT_W_P-1:0]  amount,
	// Rotated low bits
	output logic      [SLICE_W_P-1:0]   rotated
);

	// ****************************************************************
	// One selector per output bit
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < SLICE_W_P; gi++) begin : g_bit
			logic [AMOUNT_W_P-1:0] src_idx;
			// Source index wraps modulo the operand width
			assign src_idx = AMOUNT_W_P'(gi) - amount;
			assign rotated[gi] = operand[src_idx];
		end
	endgenerate

endmodule

// >>> bench/brs_bus_model.sv
// Shared data bus model that the slice result pins drive
`timescale 1ns/100ps

module brs_bus_model (
	// Clock
	input  wire logic       aclk,
	// Slice pins
	input  wire logic [3:0] slice_result,
	input  wire logic [3:0] slice_result_oe_n,
	// Resolved bus level
	output logic      [3:0] bus_value
);
	logic [3:0] float_q = 4'h5;

	// Released lines never hold the last value, so they flip every cycle
	always_ff @(posedge aclk) begin
		float_q <= ~bus_value;
	end

	// A line follows the slice only while its driver is on
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			bus_value[i] = slice_result_oe_n[i] ? float_q[i] : slice_result[i];
		end
	end
endmodule

// >>> bench/brs_slice_tb.sv
// Self-checking testbench for the registered rotator slice
`timescale 1ns/100ps

module brs_slice_tb
	import brs_pkg::*;
;
	logic        aclk, aresetn, set_n, drive_en_n, drv_off, st, en;
	logic [7:0]  operand, d;
	logic [2:0]  rotate_amount, s;
	logic [3:0]  slice_result, slice_result_oe_n, bus_value, awa, ara, ws;
	logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [31:0] wd, rd, seed;
	logic [1:0]  bp, rp;
	int          miscompares, checks_done;

	brs_slice u_brs_slice (
		.aclk(aclk), .aresetn(aresetn), .operand(operand),
		.rotate_amount(rotate_amount), .set_n(set_n), .drive_en_n(drive_en_n),
		.slice_result(slice_result), .slice_result_oe_n(slice_result_oe_n),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rp)
	);

	brs_bus_model u_brs_bus_model (
		.aclk(aclk), .slice_result(slice_result),
		.slice_result_oe_n(slice_result_oe_n), .bus_value(bus_value)
	);

	// Clock at 25 MHz
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ****************************************************************
	// Reference functions and shared tasks
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
	endfunction

	// Rotate left and pick the low or the high nibble
	function automatic logic [3:0] rot(input logic [7:0] v, input logic [2:0] n, input logic hi);
		logic [15:0] t;
		t = {v, v} << n;
		return hi ? t[15:12] : t[11:8];
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	// One data path cycle: drive, let the edge capture, then compare
	task automatic step(input logic [7:0] v, input logic [2:0] n, input logic sn,
			input logic dn, input logic [3:0] e);
		@(posedge aclk);
		operand <= v;
		rotate_amount <= n;
		set_n <= sn;
		drive_en_n <= dn;
		@(posedge aclk);
		#1;
		chk("result", {28'h0, e}, {28'h0, slice_result});
		chk("oe_n", {28'h0, {4{dn | drv_off}}}, {28'h0, slice_result_oe_n});
		if ((dn | drv_off) == 1'b0) chk("bus", {28'h0, e}, {28'h0, bus_value});
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awa <= a;
		wd <= v;
		ws <= 4'hf;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wr === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1);
		br <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bp});
	endtask

	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ev, input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1);
		rr <= 1'b0;
		chk("rdata", ev, rd);
		chk("rresp", {30'h0, er}, {30'h0, rp});
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#(40 * 5000);
		miscompares++;
		complete_run;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{aresetn, operand, rotate_amount, drive_en_n, drv_off} = '0;
		{awv, wv, br, arv, rr, awa, ara, wd, ws} = '0;
		set_n = 1'b1;
		miscompares = 0;
		checks_done = 0;
		seed = 32'h5f668c82;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk("reset result", {28'h0, RESULT_RST}, {28'h0, slice_result});
		axi_rd(STATUS_OFS, 32'h10, RESP_OKAY);
		axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
		// Every amount with wrapping bits, and the upper slice fed offset by four
		for (int i = 0; i < 8; i++) begin
			step(8'h81, i[2:0], 1'b1, 1'b0, rot(8'h81, i[2:0], 1'b0));
			step(8'h69, i[2:0], 1'b1, 1'b0, rot(8'h96, i[2:0], 1'b1));
		end
		// Random data, amount, set and enable on all thirteen inputs
		repeat (300) begin
			seed = lfsr(seed);
			{d, s, st, en} = {seed[7:0], seed[10:8], |seed[14:12], seed[16]};
			step(d, s, st, en, st ? rot(d, s, 1'b0) : 4'hf);
		end
		// Register disable: drivers off while the register keeps running
		axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
		drv_off = 1'b1;
		axi_rd(CTRL_OFS, 32'h1, RESP_OKAY);
		step(8'h12, 3'd2, 1'b1, 1'b0, rot(8'h12, 3'd2, 1'b0));
		axi_rd(STATUS_OFS, {28'h0, rot(8'h12, 3'd2, 1'b0)}, RESP_OKAY);
		axi_rd(SAMPLE_OFS, 32'h212, RESP_OKAY);
		axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
		drv_off = 1'b0;
		// Soft set pulse: all ones stand for one cycle, from the edge that ends the answer
		axi_wr(CTRL_OFS, 32'h2, RESP_OKAY);
		#1;
		chk("soft set", 32'hf, {28'h0, slice_result});
		@(posedge aclk);
		#1;
		chk("soft set end", {28'h0, rot(8'h12, 3'd2, 1'b0)}, {28'h0, slice_result});
		axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
		// Read-only and unmapped places
		axi_wr(STATUS_OFS, 32'hff, RESP_SLVERR);
		axi_wr(4'hc, 32'h1, RESP_DECERR);
		axi_rd(4'hc, 32'h0, RESP_DECERR);
		axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
		complete_run;
	end
endmodule
